// ### src/pmc_pkg.sv
// package of the power mode controller: register map, fields, states
// assumes a 32-bit avalon-mm slave port and one 200 mhz core clock
package pmc_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_CTL_ONE = 5'h00;
  localparam logic [4:0] OFS_CTL_TWO = 5'h04;
  localparam logic [4:0] OFS_WTC = 5'h08;
  localparam logic [4:0] OFS_IEN = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;
  // system_control_one fields
  localparam int CTL1_SSEL = 0;
  localparam int CTL1_LOW_SPEED_ON = 1;
  localparam int CTL1_STS_LO = 2;
  localparam int CTL1_STS_HI = 4;
  // system_control_two fields
  localparam int CTL2_SA_LO = 0;
  localparam int CTL2_SA_HI = 1;
  localparam int CTL2_MEDIUM_SPEED_ON = 2;
  localparam int CTL2_DIRECT_TRANSFER_ON = 3;
  // watch_timer_control field
  localparam int WTC_SEL = 0;
  // interrupt enable / request vector layout
  localparam int IEN_TMR_A = 5;
  localparam int IEN_TMR_G = 6;
  localparam int IEN_DT = 7;
  // reset values
  localparam logic [4:0] CTL1_RST = 5'h00;
  localparam logic [3:0] CTL2_RST = 4'h0;
  localparam logic [15:0] IEN_RST = 16'h0000;
  // wake sources accepted in each halted mode
  localparam logic [15:0] SRC_SLEEP = 16'hff7f;
  localparam logic [15:0] SRC_STBY = 16'hff03;
  localparam logic [15:0] SRC_WATCH = 16'hff21;
  localparam logic [15:0] SRC_SUBSLP = 16'hff7f;
  // timing counts in states
  localparam logic [3:0] DT_OLD_STATES = 4'h3;
  localparam logic [3:0] DT_EXC_STATES = 4'he;
  localparam int SETTLE_BASE_STATES = 8192;
  localparam logic [2:0] MED_DIV = 3'h7;
  // running clock selections
  typedef enum logic [1:0] {RUN_HIGH = 2'h0, RUN_MED = 2'h1, RUN_SUB = 2'h2} pmc_run_t;
  // controller states
  typedef enum logic [9:0] {
    ST_HIGH = 10'h001, ST_MED = 10'h002, ST_SUB = 10'h004, ST_SLEEP = 10'h008,
    ST_STBY = 10'h010, ST_WATCH = 10'h020, ST_SUBSLP = 10'h040, ST_DTOLD = 10'h080,
    ST_SETTLE = 10'h100, ST_EXC = 10'h200
  } pmc_state_t;
endpackage : pmc_pkg

// ### src/pmc_clkdiv.sv
// state tick generator for the selected cpu clock
// assumes watch_tick is a one-cycle pulse per watch clock period
`timescale 1ns/1ps
module pmc_clkdiv (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // selection
  input wire logic [1:0] div_sel,
  input wire logic [1:0] sub_div,
  input wire logic watch_tick,
  // tick out
  output logic state_tick
);
  logic [2:0] cnt_q;
  logic src;
  logic [2:0] lim;

  // source and terminal count per clock choice
  always_comb begin
    src = 1'b1;
    lim = 3'h0;
    case (div_sel)
      pmc_pkg::RUN_MED: lim = pmc_pkg::MED_DIV;
      pmc_pkg::RUN_SUB: begin
        src = watch_tick;
        lim = sub_div[1] ? 3'h1 : (sub_div[0] ? 3'h3 : 3'h7);
      end
      default: lim = 3'h0;
    endcase
  end

  // tick in the wrap cycle, so no old tick leaks into a new clock
  assign state_tick = src & (cnt_q >= lim);

  // divider counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else begin
      if (src) begin
        if (cnt_q >= lim) begin
          cnt_q <= 3'h0;
        end else begin
          cnt_q <= cnt_q + 3'h1;
        end
      end
    end
  end
endmodule : pmc_clkdiv

// ### src/pmc_settle.sv
// oscillator settling wait counter
// assumes load is a one-cycle pulse and tick counts system clock states
`timescale 1ns/1ps
module pmc_settle #(
  parameter int SETTLE_BASE = pmc_pkg::SETTLE_BASE_STATES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [2:0] code,
  input wire logic tick,
  // status
  output logic busy,
  output logic done
);
  logic [17:0] cnt_q;
  logic [17:0] span;

  // wait length: base times 1,2,4,8, or 16 when top bit set
  always_comb begin
    span = 18'(SETTLE_BASE);
    if (code[2]) span = 18'(SETTLE_BASE * 16);
    else span = 18'(SETTLE_BASE << code[1:0]);
  end

  // count down ticks; done pulses on the last one
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 18'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= span - 18'h1;
        busy <= 1'b1;
      end else if (busy && tick) begin
        if (cnt_q == 18'h0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 18'h1;
        end
      end
    end
  end
endmodule : pmc_settle

// ### src/pmc_ctrl.sv
// power mode controller: sleep decode, wake qualification, direct transfer
// assumes sleep_req and interrupt requests are synchronous to core_clk
//
// Operation
// R1: subactive sleep, ssel0 lson1 wsel1 gives subsleep
// R2: subsleep halts all but timers A, G, LCD
// R3: subsleep left only by listed wakes or reset
// R4: masked or disabled wake keeps subsleep
// R5: watch wake with lson1 gives subactive
// R6: subsleep wake returns to subactive
// R7: subactive sleep, ssel1 wsel1 gives watch
// R8: subactive cpu clock is watch clock /2,/4,/8
// R9: mson1 lson0 wakes into medium-speed mode
// R10: medium sleep enters standby or watch
// R11: medium sleep, ssel0 lson0 enters sleep
// R12: reset pin low leaves medium-speed mode
// R13: medium-speed cpu clock is high-speed over eight
// R14: sleep with dton1 switches running mode directly
// R15: direct transfer interrupt disabled gives sleep/watch
// R16: masked direct transfer gives sleep/watch, unwakeable
// R17: high to medium via sleep
// R18: medium to high via sleep
// R19: active to subactive via watch
// R20: subactive to active after settling wait
// R21: three old states then fourteen new states
// R22: settling wait before exception when leaving subactive
// R23: reset pin starts oscillator, clears mode
// R24: settle code picks 8192 to 131072 states
// R25: medium_speed_on selects resumed mode, resets 0
// R26: encoded mode register reset to high-speed
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module pmc_ctrl #(
  parameter int SETTLE_BASE = pmc_pkg::SETTLE_BASE_STATES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata_q,
  output logic avs_waitrequest_q,
  // cpu side
  input wire logic sleep_req,
  input wire logic cpu_int_mask,
  input wire logic reset_pin_n,
  // interrupt requests
  input wire logic [4:0] ext_irq_req,
  input wire logic [7:0] wakeup_input,
  input wire logic timer_a_req,
  input wire logic timer_g_req,
  input wire logic other_irq_req,
  // watch clock tick
  input wire logic watch_tick,
  // mode outputs
  output logic cpu_halt_q,
  output logic cpu_reset_q,
  output logic periph_halt_q,
  output logic timer_g_halt_q,
  output logic port_hiz_q,
  output logic sys_osc_on_q,
  output logic [3:0] cpu_clk_ratio_q,
  output logic cpu_clk_sub_q,
  output logic exc_start_q,
  output logic exc_busy_q,
  output logic dt_exc_q
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [4:0] ctl1_q;
  logic [3:0] ctl2_q;
  logic wtc_q;
  logic [15:0] ien_q;
  pmc_pkg::pmc_state_t state_q;
  pmc_pkg::pmc_run_t tgt_q;
  pmc_pkg::pmc_run_t src_q;
  pmc_pkg::pmc_run_t dsel;
  logic [3:0] seq_q;
  logic dt_q;
  logic settle_go_q;
  logic settle_busy;
  logic settle_done;
  logic state_tick;
  logic [15:0] req_vec;
  logic ssel, low_speed_on, medium_speed_on, direct_transfer_on, wsel, dt_ok;
  pmc_pkg::pmc_run_t wake_run;
  logic acc;

  // qualified wake: request enabled, accepted in this mode, not masked
  function automatic logic pmc_hit(input logic [15:0] req, input logic [15:0] en,
                                   input logic [15:0] src, input logic mask);
    pmc_hit = (|(req & en & src)) & ~mask;
  endfunction : pmc_hit

  ////////////////////////////////////////////////////////////////////////////
  // field decode
  assign ssel = ctl1_q[pmc_pkg::CTL1_SSEL];
  assign low_speed_on = ctl1_q[pmc_pkg::CTL1_LOW_SPEED_ON];
  assign medium_speed_on = ctl2_q[pmc_pkg::CTL2_MEDIUM_SPEED_ON];
  assign direct_transfer_on = ctl2_q[pmc_pkg::CTL2_DIRECT_TRANSFER_ON];
  assign wsel = wtc_q;
  assign dt_ok = ien_q[pmc_pkg::IEN_DT] & ~cpu_int_mask; // [R15] [R16]
  assign wake_run = medium_speed_on ? pmc_pkg::RUN_MED : pmc_pkg::RUN_HIGH; // [R25]
  assign req_vec = {wakeup_input, 1'b0, timer_g_req, timer_a_req, ext_irq_req};
  assign acc = (avs_read | avs_write) & avs_waitrequest_q;

  ////////////////////////////////////////////////////////////////////////////
  // avalon handshake: waitrequest drops one cycle after a request appears
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest_q <= 1'b1;
    end else if (acc) begin
      avs_waitrequest_q <= 1'b0;
    end else begin
      avs_waitrequest_q <= 1'b1;
    end
  end

  // register writes on the accepting edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl1_q <= pmc_pkg::CTL1_RST;
      ctl2_q <= pmc_pkg::CTL2_RST;
      wtc_q <= 1'b0;
      ien_q <= pmc_pkg::IEN_RST;
    end else if (avs_write && !avs_waitrequest_q) begin
      case (avs_address)
        pmc_pkg::OFS_CTL_ONE: ctl1_q <= avs_writedata[4:0];
        pmc_pkg::OFS_CTL_TWO: begin
          ctl2_q[3:2] <= avs_writedata[3:2];
          // clock select is frozen while in subactive mode (ST_SUB)
          if (state_q != pmc_pkg::ST_SUB) ctl2_q[1:0] <= avs_writedata[1:0];
        end
        pmc_pkg::OFS_WTC: wtc_q <= avs_writedata[pmc_pkg::WTC_SEL];
        pmc_pkg::OFS_IEN: ien_q <= avs_writedata[15:0];
        default: ctl1_q <= ctl1_q;
      endcase
    end
  end

  // read data captured on the same edge that drops waitrequest
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata_q <= 32'h0;
    end else if (acc && avs_read) begin
      case (avs_address)
        pmc_pkg::OFS_CTL_ONE: avs_readdata_q <= {27'h0, ctl1_q};
        pmc_pkg::OFS_CTL_TWO: avs_readdata_q <= {28'h0, ctl2_q};
        pmc_pkg::OFS_WTC: avs_readdata_q <= {31'h0, wtc_q};
        pmc_pkg::OFS_IEN: avs_readdata_q <= {16'h0, ien_q};
        pmc_pkg::OFS_STATUS: avs_readdata_q <= {18'h0, settle_busy, dt_q, tgt_q, state_q};
        default: avs_readdata_q <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock source for state counting in each phase
  always_comb begin
    case (state_q)
      pmc_pkg::ST_MED: dsel = pmc_pkg::RUN_MED;
      pmc_pkg::ST_SUB: dsel = pmc_pkg::RUN_SUB;
      pmc_pkg::ST_DTOLD: dsel = src_q; // [R21]
      pmc_pkg::ST_EXC: dsel = tgt_q; // [R21]
      default: dsel = pmc_pkg::RUN_HIGH; // settle counts system clock states [R22]
    endcase
  end

  pmc_clkdiv u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .div_sel(dsel),
    .sub_div(ctl2_q[1:0]),
    .watch_tick(watch_tick),
    .state_tick(state_tick)
  );

  pmc_settle #(.SETTLE_BASE(SETTLE_BASE)) u_settle (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(settle_go_q),
    .code(ctl1_q[pmc_pkg::CTL1_STS_HI:pmc_pkg::CTL1_STS_LO]), // [R24]
    .tick(state_tick),
    .busy(settle_busy),
    .done(settle_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode state machine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pmc_pkg::ST_HIGH; // [R26]
      tgt_q <= pmc_pkg::RUN_HIGH;
      src_q <= pmc_pkg::RUN_HIGH;
      seq_q <= 4'h0;
      dt_q <= 1'b0;
      settle_go_q <= 1'b0;
      exc_start_q <= 1'b0;
    end else begin
      settle_go_q <= 1'b0;
      exc_start_q <= 1'b0;
      if (!reset_pin_n) begin
        state_q <= pmc_pkg::ST_HIGH; // [R12] [R23]
        tgt_q <= pmc_pkg::RUN_HIGH;
        seq_q <= 4'h0;
        dt_q <= 1'b0;
      end else begin
        case (state_q)
          pmc_pkg::ST_HIGH, pmc_pkg::ST_MED: begin
            if (sleep_req) begin
              src_q <= (state_q == pmc_pkg::ST_MED) ? pmc_pkg::RUN_MED : pmc_pkg::RUN_HIGH;
              seq_q <= 4'h0;
              if (ssel && low_speed_on && wsel && direct_transfer_on) begin
                if (dt_ok) begin
                  state_q <= pmc_pkg::ST_DTOLD; // [R14] [R19]
                  tgt_q <= pmc_pkg::RUN_SUB;
                  dt_q <= 1'b1;
                end else begin
                  state_q <= pmc_pkg::ST_WATCH; // [R15] [R16]
                end
              end else if (!ssel && !low_speed_on && direct_transfer_on && (medium_speed_on ^ (state_q == pmc_pkg::ST_MED))) begin
                if (dt_ok) begin
                  state_q <= pmc_pkg::ST_DTOLD; // [R17] [R18]
                  tgt_q <= wake_run;
                  dt_q <= 1'b1;
                end else begin
                  state_q <= pmc_pkg::ST_SLEEP; // [R15] [R16]
                end
              end else if (!ssel && !low_speed_on) begin
                state_q <= pmc_pkg::ST_SLEEP; // [R11]
              end else if (ssel && !low_speed_on && !wsel) begin
                state_q <= pmc_pkg::ST_STBY; // [R10]
              end else if (ssel && wsel) begin
                state_q <= pmc_pkg::ST_WATCH; // [R10]
              end
            end
          end
          pmc_pkg::ST_SUB: begin
            if (sleep_req) begin
              src_q <= pmc_pkg::RUN_SUB;
              seq_q <= 4'h0;
              if (ssel && wsel && direct_transfer_on && !low_speed_on && dt_ok) begin
                state_q <= pmc_pkg::ST_DTOLD; // [R20] [R14]
                tgt_q <= wake_run;
                dt_q <= 1'b1;
              end else if (ssel && wsel) begin
                state_q <= pmc_pkg::ST_WATCH; // [R7] [R15] [R16]
              end else if (!ssel && low_speed_on && wsel) begin
                state_q <= pmc_pkg::ST_SUBSLP; // [R1]
              end
            end
          end
          pmc_pkg::ST_SLEEP: begin
            if (pmc_hit(req_vec, ien_q, pmc_pkg::SRC_SLEEP, cpu_int_mask) ||
                (other_irq_req && !cpu_int_mask)) begin
              state_q <= pmc_pkg::ST_EXC; // [R9]
              tgt_q <= wake_run;
              seq_q <= 4'h0;
              dt_q <= 1'b0;
              exc_start_q <= 1'b1;
            end
          end
          pmc_pkg::ST_STBY: begin
            if (pmc_hit(req_vec, ien_q, pmc_pkg::SRC_STBY, cpu_int_mask)) begin
              state_q <= pmc_pkg::ST_SETTLE; // [R9]
              tgt_q <= wake_run;
              dt_q <= 1'b0;
              settle_go_q <= 1'b1;
            end
          end
          pmc_pkg::ST_WATCH: begin
            if (pmc_hit(req_vec, ien_q, pmc_pkg::SRC_WATCH, cpu_int_mask)) begin
              dt_q <= 1'b0;
              seq_q <= 4'h0;
              if (low_speed_on) begin
                state_q <= pmc_pkg::ST_EXC; // [R5]
                tgt_q <= pmc_pkg::RUN_SUB;
                exc_start_q <= 1'b1;
              end else begin
                state_q <= pmc_pkg::ST_SETTLE; // [R9]
                tgt_q <= wake_run;
                settle_go_q <= 1'b1;
              end
            end
          end
          pmc_pkg::ST_SUBSLP: begin
            // apart from the reset pin, only listed, enabled, unmasked wakes leave subsleep
            if (pmc_hit(req_vec, ien_q, pmc_pkg::SRC_SUBSLP, cpu_int_mask)) begin
              state_q <= pmc_pkg::ST_EXC; // [R3] [R4] [R6]
              tgt_q <= pmc_pkg::RUN_SUB;
              seq_q <= 4'h0;
              dt_q <= 1'b0;
              exc_start_q <= 1'b1;
            end
          end
          pmc_pkg::ST_DTOLD: begin
            // sleep instruction plus internal state in the old clock
            if (state_tick) begin
              if (seq_q == pmc_pkg::DT_OLD_STATES - 4'h1) begin
                seq_q <= 4'h0;
                if (src_q == pmc_pkg::RUN_SUB) begin
                  state_q <= pmc_pkg::ST_SETTLE; // [R20] [R22]
                  settle_go_q <= 1'b1;
                end else begin
                  state_q <= pmc_pkg::ST_EXC; // [R21]
                  exc_start_q <= 1'b1;
                end
              end else begin
                seq_q <= seq_q + 4'h1;
              end
            end
          end
          pmc_pkg::ST_SETTLE: begin
            if (settle_done) begin
              state_q <= pmc_pkg::ST_EXC; // [R22]
              seq_q <= 4'h0;
              exc_start_q <= 1'b1;
            end
          end
          pmc_pkg::ST_EXC: begin
            // exception handling states in the new clock
            if (state_tick) begin
              if (seq_q == pmc_pkg::DT_EXC_STATES - 4'h1) begin
                seq_q <= 4'h0;
                dt_q <= 1'b0;
                case (tgt_q)
                  pmc_pkg::RUN_MED: state_q <= pmc_pkg::ST_MED;
                  pmc_pkg::RUN_SUB: state_q <= pmc_pkg::ST_SUB;
                  default: state_q <= pmc_pkg::ST_HIGH;
                endcase
              end else begin
                seq_q <= seq_q + 4'h1; // [R21]
              end
            end
          end
          default: state_q <= pmc_pkg::ST_HIGH;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // halt, port and oscillator controls from the mode
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt_q <= 1'b0;
      cpu_reset_q <= 1'b1;
      periph_halt_q <= 1'b0;
      timer_g_halt_q <= 1'b0;
      port_hiz_q <= 1'b0;
      sys_osc_on_q <= 1'b1;
    end else begin
      cpu_reset_q <= ~reset_pin_n; // [R12] [R23]
      cpu_halt_q <= (state_q == pmc_pkg::ST_SLEEP) || (state_q == pmc_pkg::ST_STBY) ||
                    (state_q == pmc_pkg::ST_WATCH) || (state_q == pmc_pkg::ST_SUBSLP) ||
                    (state_q == pmc_pkg::ST_SETTLE);
      periph_halt_q <= (state_q == pmc_pkg::ST_SUBSLP) || (state_q == pmc_pkg::ST_WATCH) ||
                       (state_q == pmc_pkg::ST_STBY); // [R2]
      timer_g_halt_q <= (state_q == pmc_pkg::ST_WATCH) || (state_q == pmc_pkg::ST_STBY);
      port_hiz_q <= (state_q == pmc_pkg::ST_STBY);
      // system oscillator off while parked on the watch clock
      sys_osc_on_q <= ~reset_pin_n || !((state_q == pmc_pkg::ST_STBY) ||
                      (state_q == pmc_pkg::ST_WATCH) || (state_q == pmc_pkg::ST_SUBSLP) ||
                      (state_q == pmc_pkg::ST_SUB) ||
                      ((state_q == pmc_pkg::ST_EXC) && (tgt_q == pmc_pkg::RUN_SUB)) ||
                      ((state_q == pmc_pkg::ST_DTOLD) && (src_q == pmc_pkg::RUN_SUB))); // [R23]
    end
  end

  // cpu clock ratio and source
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_ratio_q <= 4'h1;
      cpu_clk_sub_q <= 1'b0;
      exc_busy_q <= 1'b0;
      dt_exc_q <= 1'b0;
    end else begin
      cpu_clk_sub_q <= (dsel == pmc_pkg::RUN_SUB);
      case (dsel)
        pmc_pkg::RUN_MED: cpu_clk_ratio_q <= 4'h8; // [R13]
        pmc_pkg::RUN_SUB: cpu_clk_ratio_q <= ctl2_q[1] ? 4'h2 : (ctl2_q[0] ? 4'h4 : 4'h8); // [R8]
        default: cpu_clk_ratio_q <= 4'h1;
      endcase
      exc_busy_q <= (state_q == pmc_pkg::ST_EXC);
      dt_exc_q <= dt_q && (state_q == pmc_pkg::ST_EXC); // [R14]
    end
  end
endmodule : pmc_ctrl

// ### verif/pmc_ctrl_sva.sv
// port checker of the power mode controller
// assumes one core_clk domain and the bind at the foot of this file
`timescale 1ns/1ps
module pmc_ctrl_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bus and cpu side
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest_q,
  input wire logic cpu_int_mask,
  input wire logic reset_pin_n,
  // mode outputs
  input wire logic cpu_halt_q,
  input wire logic cpu_reset_q,
  input wire logic periph_halt_q,
  input wire logic timer_g_halt_q,
  input wire logic port_hiz_q,
  input wire logic sys_osc_on_q,
  input wire logic [3:0] cpu_clk_ratio_q,
  input wire logic cpu_clk_sub_q,
  input wire logic exc_start_q
);
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  // pin low for two edges, and a halt seen with the mask set twice
  sequence s_pin_low;
    !reset_pin_n [*2];
  endsequence
  sequence s_masked_halt;
    cpu_int_mask && reset_pin_n ##1 periph_halt_q && cpu_int_mask && reset_pin_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////
  // bus answer and mode relations
  AST_BUS_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest_q |=>
    !avs_waitrequest_q) else $error("bus request not answered");
  AST_BUS_ONE: assert property ($fell(avs_waitrequest_q) |=> avs_waitrequest_q)
    else $error("waitrequest low too long");
  AST_PIN_CPU: assert property ($fell(reset_pin_n) |=> cpu_reset_q)
    else $error("cpu not reset by pin");
  AST_PIN_CLEAR: assert property (s_pin_low |=> sys_osc_on_q && !cpu_halt_q &&
    !cpu_clk_sub_q && cpu_clk_ratio_q == 4'h1) else $error("pin low did not clear mode");
  AST_SUB_DIV: assert property (cpu_clk_sub_q |-> cpu_clk_ratio_q inside {4'h2, 4'h4, 4'h8})
    else $error("bad subactive divider");
  AST_PERIPH: assert property (periph_halt_q |-> cpu_halt_q)
    else $error("peripherals halted with cpu running");
  AST_HIZ: assert property (port_hiz_q |-> periph_halt_q && timer_g_halt_q)
    else $error("ports floating outside standby");
  AST_MASK_HOLD: assert property (s_masked_halt |=> periph_halt_q)
    else $error("masked wake left halt");
  AST_EXC_PULSE: assert property (exc_start_q |=> !exc_start_q)
    else $error("exception start longer than one cycle");
endmodule : pmc_ctrl_sva

bind pmc_ctrl pmc_ctrl_sva u_sva (.*);

// ### verif/pmc_cpu_model.sv
// cpu and watch oscillator model facing the power mode controller
// assumes the bench raises sleep_cmd for one cycle per sleep instruction
`timescale 1ns/1ps
module pmc_cpu_model #(
  parameter int WATCH_DIV = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // bench command and controller status
  input wire logic sleep_cmd,
  input wire logic cpu_halt_q,
  // to the controller
  output logic sleep_req,
  output logic watch_tick
);
  int cnt;
  // a halted cpu runs no instruction, so it issues no sleep
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_req <= 1'h0;
    end else begin
      sleep_req <= sleep_cmd && !cpu_halt_q;
    end
  end
  // free-running watch oscillator, one tick a period
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      watch_tick <= 1'h0;
    end else begin
      cnt <= (cnt == WATCH_DIV - 1) ? 0 : cnt + 1;
      watch_tick <= (cnt == WATCH_DIV - 1);
    end
  end
endmodule : pmc_cpu_model

// ### verif/pmc_ctrl_tb.sv
// self-checking bench of the power mode controller
// assumes design, model and bound checker compiled before it
`timescale 1ns/1ps
module pmc_ctrl_tb;
  logic core_clk = 1'h0, rst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [4:0] avs_address = 5'h00, ext_irq_req = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata_q;
  logic sleep_cmd = 1'h0, cpu_int_mask = 1'h0, reset_pin_n = 1'h1, timer_a_req = 1'h0;
  logic timer_g_req = 1'h0, other_irq_req = 1'h0, sleep_req, watch_tick, avs_waitrequest_q;
  logic [7:0] wakeup_input = 8'h00;
  logic cpu_halt_q, cpu_reset_q, periph_halt_q, timer_g_halt_q, port_hiz_q, sys_osc_on_q;
  logic cpu_clk_sub_q, exc_start_q, exc_busy_q, dt_exc_q;
  logic [3:0] cpu_clk_ratio_q;
  int n_mismatch = 0, checks = 0;
  integer seed = 32'h53e0;
  always #2.5 core_clk = ~core_clk;
  pmc_ctrl #(.SETTLE_BASE(4)) uut (.*);
  pmc_cpu_model #(.WATCH_DIV(4)) u_cpu (.*);
  ////////////////////////////////////////////////////////////////////////
  // verdict, compare, expected subactive divider
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [3:0] sub_div(input logic [1:0] sa);
    return sa[1] ? 4'h2 : (sa[0] ? 4'h4 : 4'h8);
  endfunction : sub_div
  ////////////////////////////////////////////////////////////////////////
  // avalon cycle held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest_q === 1'h0) break;
    end
    q = avs_readdata_q;
    if (i == 50) begin
      chk(1'h0, 1'h1);
      wrap_up();
    end
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge core_clk);
  endtask : bus
  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2, input logic wt,
                     input logic [15:0] en);
    logic [31:0] q;
    bus(1'h1, pmc_pkg::OFS_CTL_ONE, {24'h0, c1}, q);
    bus(1'h1, pmc_pkg::OFS_CTL_TWO, {24'h0, c2}, q);
    bus(1'h1, pmc_pkg::OFS_WTC, {31'h0, wt}, q);
    bus(1'h1, pmc_pkg::OFS_IEN, {16'h0, en}, q);
  endtask : cfg
  // poll the state field until it matches, bounded
  task automatic wait_st(input logic [9:0] s);
    logic [31:0] q;
    int i;
    for (i = 0; i < 400; i++) begin
      bus(1'h0, pmc_pkg::OFS_STATUS, 32'h0, q);
      if (q[9:0] === s) break;
    end
    chk(q[9:0], s);
    if (i == 400) wrap_up();
  endtask : wait_st
  task automatic sleep();
    sleep_cmd <= 1'h1;
    @(posedge core_clk);
    sleep_cmd <= 1'h0;
  endtask : sleep
  // direct transfer: length of exception handling in core clock cycles
  task automatic dt_run(input int n, input int s);
    int i, c;
    sleep();
    for (i = 0; i < 3000 && exc_busy_q !== 1'h1; i++) @(posedge core_clk);
    chk(dt_exc_q, 1'h1);
    for (c = 0; c < 3000 && exc_busy_q === 1'h1; c++) @(posedge core_clk);
    chk(c >= n - s && c <= n, 1'h1);
    if (i + c >= 3000) wrap_up();
  endtask : dt_run
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    chk(cpu_reset_q, 1'h0);
    bus(1'h0, pmc_pkg::OFS_CTL_TWO, 32'h0, q);
    chk(q, 32'h0);
    bus(1'h0, 5'h14, 32'h0, q);
    chk(q, 32'h0);
    wait_st(pmc_pkg::ST_HIGH);
    cfg(8'h00, 8'h04, 1'h0, 16'h0020);
    sleep();
    wait_st(pmc_pkg::ST_SLEEP);
    cpu_int_mask <= 1'h1;
    timer_a_req <= 1'h1;
    repeat (8) @(posedge core_clk);
    wait_st(pmc_pkg::ST_SLEEP);
    cpu_int_mask <= 1'h0;
    wait_st(pmc_pkg::ST_MED);
    timer_a_req <= 1'h0;
    chk(cpu_clk_ratio_q, 4'h8);
    cfg(8'h01, 8'h04, 1'h0, 16'h0002);
    sleep();
    wait_st(pmc_pkg::ST_STBY);
    chk(port_hiz_q, 1'h1);
    ext_irq_req <= 5'h02;
    wait_st(pmc_pkg::ST_MED);
    ext_irq_req <= 5'h00;
    reset_pin_n <= 1'h0;
    repeat (3) @(posedge core_clk);
    chk(cpu_reset_q, 1'h1);
    reset_pin_n <= 1'h1;
    wait_st(pmc_pkg::ST_HIGH);
    $display("sleep, standby and pin tests done");
    cfg(8'h00, 8'h0c, 1'h0, 16'h0080);
    dt_run(112, 7);
    wait_st(pmc_pkg::ST_MED);
    cfg(8'h00, 8'h08, 1'h0, 16'h0080);
    dt_run(14, 0);
    wait_st(pmc_pkg::ST_HIGH);
    cfg(8'h00, 8'h0c, 1'h0, 16'h0000);
    sleep();
    wait_st(pmc_pkg::ST_SLEEP);
    other_irq_req <= 1'h1;
    wait_st(pmc_pkg::ST_MED);
    other_irq_req <= 1'h0;
    $display("direct transfer tests done");
    cfg(8'h03, 8'h08, 1'h1, 16'h0080);
    sleep();
    wait_st(pmc_pkg::ST_SUB);
    chk(cpu_clk_ratio_q, sub_div(2'h0));
    cfg(8'h02, 8'h00, 1'h1, 16'hff40);
    sleep();
    wait_st(pmc_pkg::ST_SUBSLP);
    chk({periph_halt_q, timer_g_halt_q}, 2'h2);
    cpu_int_mask <= 1'h1;
    other_irq_req <= 1'h1;
    wakeup_input <= 8'h01 << ($unsigned($random(seed)) % 8);
    repeat (8) @(posedge core_clk);
    wait_st(pmc_pkg::ST_SUBSLP);
    cpu_int_mask <= 1'h0;
    wait_st(pmc_pkg::ST_SUB);
    wakeup_input <= 8'h00;
    other_irq_req <= 1'h0;
    bus(1'h1, pmc_pkg::OFS_CTL_ONE, 32'h3, q);
    sleep();
    wait_st(pmc_pkg::ST_WATCH);
    wakeup_input <= 8'h80;
    wait_st(pmc_pkg::ST_SUB);
    cfg(8'h01, 8'h08, 1'h1, 16'h0080);
    dt_run(14, 0);
    wait_st(pmc_pkg::ST_HIGH);
    $display("subactive tests done");
    wrap_up();
  end
endmodule : pmc_ctrl_tb
